// >>> src/aic_control_unit.v
`timescale 1ns/1ps
`include "aic_control_regs.vh"

module aic_control_unit #(
	parameter DATA_W    = 10,
	parameter BUF_DEPTH = 2,
	parameter TIMER_W   = 8
) (
	// Clock, reset, enable
	input  wire               core_clk,
	input  wire               rst_b,
	input  wire               clk_en,
	// Device code switches, one means switch on
	input  wire [5:0]         code_switch_bank,
	// Processor I/O transfer bus
	input  wire               iot_valid,
	input  wire [11:0]        iot_word,
	input  wire [11:0]        accumulator_in,
	output reg  [11:0]        accumulator_out_r,
	output reg                accumulator_load_r,
	output reg                accumulator_clear_r,
	output reg                skip_r,
	output reg                iot_ack_r,
	output reg                interrupt_request_line_r,
	// Start sources
	input  wire               clock_overflow,
	input  wire               external_trigger_n,
	// Analog core side
	output reg  [3:0]         channel_selector_r,
	output reg                unipolar_mode_r,
	output reg                convert_go_r,
	input  wire               sar_valid,
	input  wire [DATA_W-1:0]  sar_data,
	output reg                sar_ready_r
);

	// Cycle counts rounded up from nanoseconds, then cut to the timer width
	localparam integer SETTLE_INT =
		(`AIC_SETTLE_NS + `AIC_CLK_NS - 1) / `AIC_CLK_NS;
	localparam integer UPDATE_INT =
		(`AIC_UPDATE_NS + `AIC_CLK_NS - 1) / `AIC_CLK_NS;
	localparam integer DEPTH_INT  = BUF_DEPTH;
	localparam [TIMER_W-1:0] SETTLE_CYC = SETTLE_INT[TIMER_W-1:0];
	localparam [TIMER_W-1:0] UPDATE_CYC = UPDATE_INT[TIMER_W-1:0];
	localparam [TIMER_W-1:0] T_ONE  = {{(TIMER_W-1){1'b0}}, 1'b1};
	localparam [TIMER_W-1:0] T_ZERO = {TIMER_W{1'b0}};
	// Buffer fill levels
	localparam [1:0] CNT_EMPTY = 2'h0;
	localparam [1:0] CNT_FULL  = DEPTH_INT[1:0];

	// Converter sequencing states
	localparam [2:0] ST_IDLE    = 3'h1;
	localparam [2:0] ST_SETTLE  = 3'h2;
	localparam [2:0] ST_CONVERT = 3'h4;

	// Matches one operation against a decoded instruction
	function is_op;
		input       hit;
		input [2:0] op;
		input [2:0] want;
		begin
			is_op = hit & (op == want);
		end
	endfunction

	// Sequencer and timers
	reg  [2:0]         state_r;
	reg  [2:0]         state_nxt;
	reg  [TIMER_W-1:0] settle_r;
	reg  [TIMER_W-1:0] update_r;

	// Status, enable and result registers
	reg                done_r;
	reg                err_r;
	reg  [5:0]         en_r;
	reg  [11:0]        result_r;
	reg                trig_prev_r;

	// Two-entry result buffer
	reg  [DATA_W-1:0]  buf_mem_r [0:BUF_DEPTH-1];
	reg                wr_ptr_r;
	reg                rd_ptr_r;
	reg  [1:0]         buf_cnt_r;

	// Decode strobes
	wire [5:0]  dev_code;
	wire        hit;
	wire [2:0]  op;
	wire        op_clear;
	wire        op_lchan;
	wire        op_begin;
	wire        op_read;
	wire        op_skd;
	wire        op_ske;
	wire        op_len;
	wire        op_regs;

	// Start and buffer control
	wire        ext_edge;
	wire        hw_start;
	wire        any_start;
	wire        busy;
	wire        push;
	wire        pop;
	wire        update_due;
	wire [1:0]  cnt_nxt;
	wire [DATA_W-1:0] buf_head;

	// Next values of the registered state
	reg  [TIMER_W-1:0] settle_nxt;
	reg  [TIMER_W-1:0] update_nxt;
	reg                done_nxt;
	reg                err_nxt;
	reg  [5:0]         en_nxt;
	reg  [3:0]         chan_nxt;
	reg  [11:0]        acc_word_nxt;
	reg                irq_nxt;

	// Switch off decodes a one; first used switch is bit 5
	assign dev_code = ~code_switch_bank;

	// Instruction decode
	assign hit = iot_valid
		& (iot_word[`AIC_IOT_PRE_HI:`AIC_IOT_PRE_LO] == `AIC_IOT_PREFIX)
		& (iot_word[`AIC_IOT_DEV_HI:`AIC_IOT_DEV_LO] == dev_code);
	assign op       = iot_word[`AIC_IOT_OP_HI:`AIC_IOT_OP_LO];
	assign op_clear = is_op(hit, op, `AIC_OP_CLEAR_ALL);
	assign op_lchan = is_op(hit, op, `AIC_OP_LOAD_CHAN);
	assign op_begin = is_op(hit, op, `AIC_OP_BEGIN);
	assign op_read  = is_op(hit, op, `AIC_OP_READ_RES);
	assign op_skd   = is_op(hit, op, `AIC_OP_SKIP_DONE);
	assign op_ske   = is_op(hit, op, `AIC_OP_SKIP_ERR);
	assign op_len   = is_op(hit, op, `AIC_OP_LOAD_EN);
	assign op_regs  = is_op(hit, op, `AIC_OP_READ_REGS);

	// Start sources; hardware starts gated by enable
	assign ext_edge  = trig_prev_r & ~external_trigger_n;
	assign hw_start  = en_r[`AIC_EN_EXT_START] & (clock_overflow | ext_edge);
	assign any_start = op_begin | hw_start;
	assign busy      = ~state_r[0];

	// Buffer handshakes and delayed update
	assign push       = sar_valid & sar_ready_r & state_r[2];
	assign update_due = (update_r == T_ONE);
	assign pop        = update_due & (buf_cnt_r != CNT_EMPTY);
	assign cnt_nxt    = buf_cnt_r + {1'b0, push} - {1'b0, pop};
	assign buf_head   = buf_mem_r[rd_ptr_r];

	// Sequencer next state
	always @* begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (any_start)
					state_nxt = ST_SETTLE;
			end
			ST_SETTLE: begin
				if (settle_r == T_ONE)
					state_nxt = ST_CONVERT;
			end
			ST_CONVERT: begin
				if (push)
					state_nxt = ST_IDLE;
			end
			default: state_nxt = ST_IDLE;
		endcase
	end

	// Settle countdown, loaded by an accepted start
	always @* begin
		settle_nxt = settle_r;
		if (state_r[0] & any_start)
			settle_nxt = SETTLE_CYC;
		else if (settle_r != T_ZERO)
			settle_nxt = settle_r - T_ONE;
	end

	// Sequencer, settle timer and conversion kick
	always @(posedge core_clk) begin
		if (!rst_b) begin
			state_r      <= ST_IDLE;
			settle_r     <= T_ZERO;
			convert_go_r <= 1'b0;
		end else if (clk_en) begin
			state_r      <= state_nxt;
			settle_r     <= settle_nxt;
			convert_go_r <= state_r[1] & (settle_r == T_ONE);
		end
	end

	// Trigger history; starts high so reset shows no false edge
	always @(posedge core_clk) begin
		if (!rst_b)
			trig_prev_r <= 1'b1;
		else if (clk_en)
			trig_prev_r <= external_trigger_n;
	end

	// Two-entry result buffer between converter and result word
	always @(posedge core_clk) begin
		if (!rst_b) begin
			wr_ptr_r    <= 1'b0;
			rd_ptr_r    <= 1'b0;
			buf_cnt_r   <= 2'h0;
			sar_ready_r <= 1'b0;
		end else if (clk_en) begin
			if (push)
				wr_ptr_r <= ~wr_ptr_r;
			if (pop)
				rd_ptr_r <= ~rd_ptr_r;
			buf_cnt_r   <= cnt_nxt;
			sar_ready_r <= (cnt_nxt != CNT_FULL);
		end
	end

	// Buffer storage, written only on an accepted result
	always @(posedge core_clk) begin
		if (clk_en & push)
			buf_mem_r[wr_ptr_r] <= sar_data;
	end

	// Update delay: restarted by a new result or a waiting second entry
	always @* begin
		update_nxt = update_r;
		if (push)
			update_nxt = UPDATE_CYC;
		else if (update_due & (cnt_nxt != CNT_EMPTY))
			update_nxt = UPDATE_CYC;
		else if (update_r != T_ZERO)
			update_nxt = update_r - T_ONE;
	end

	// Delay from done to result update
	always @(posedge core_clk) begin
		if (!rst_b) begin
			update_r <= T_ZERO;
			result_r <= `AIC_RST_WORD;
		end else if (clk_en) begin
			update_r <= update_nxt;
			if (pop)
				result_r <= {{(12-DATA_W){buf_head[DATA_W-1]}}, buf_head};
		end
	end

	// Status flag next values; a hardware set wins over a clear
	always @* begin
		done_nxt = done_r;
		err_nxt  = err_r;
		if (op_clear | op_begin | op_read)
			done_nxt = 1'b0;
		if (push)
			done_nxt = 1'b1;
		if (op_clear | op_begin)
			err_nxt = 1'b0;
		if ((any_start & busy) | (pop & op_read))
			err_nxt = 1'b1;
	end

	// Status flags
	always @(posedge core_clk) begin
		if (!rst_b) begin
			done_r <= `AIC_RST_FLAG;
			err_r  <= `AIC_RST_FLAG;
		end else if (clk_en) begin
			done_r <= done_nxt;
			err_r  <= err_nxt;
		end
	end

	// Enable and channel next values
	always @* begin
		en_nxt   = en_r;
		chan_nxt = channel_selector_r;
		if (op_clear) begin
			en_nxt   = `AIC_RST_EN;
			chan_nxt = `AIC_RST_CHAN;
		end else begin
			if (op_len)
				en_nxt = {accumulator_in[`AIC_EN_HI:`AIC_EN_LO+1], 1'b0};
			if (op_lchan)
				chan_nxt = accumulator_in[`AIC_CHAN_HI:`AIC_CHAN_LO];
			else if (push & en_r[`AIC_EN_AUTO_INC])
				chan_nxt = channel_selector_r + 4'h1;
		end
	end

	// Enable and channel registers; range output follows its enable bit
	always @(posedge core_clk) begin
		if (!rst_b) begin
			en_r               <= `AIC_RST_EN;
			channel_selector_r <= `AIC_RST_CHAN;
			unipolar_mode_r    <= 1'b0;
		end else if (clk_en) begin
			en_r               <= en_nxt;
			channel_selector_r <= chan_nxt;
			unipolar_mode_r    <= en_nxt[`AIC_EN_UNIPOLAR];
		end
	end

	// Word handed to the processor for the two read operations
	always @* begin
		acc_word_nxt = `AIC_RST_WORD;
		if (op_read)
			acc_word_nxt = result_r;
		else if (op_regs)
			acc_word_nxt = {done_r, err_r, en_r, channel_selector_r};
	end

	// Processor answer pulses: acknowledge, clear, load, skip
	always @(posedge core_clk) begin
		if (!rst_b) begin
			accumulator_load_r  <= 1'b0;
			accumulator_clear_r <= 1'b0;
			skip_r              <= 1'b0;
			iot_ack_r           <= 1'b0;
		end else if (clk_en) begin
			iot_ack_r           <= hit;
			accumulator_clear_r <= op_lchan | op_len;
			accumulator_load_r  <= op_read | op_regs;
			skip_r <= (op_skd & done_r) | (op_ske & err_r);
		end
	end

	// Processor answer data, zero outside the read operations
	always @(posedge core_clk) begin
		if (!rst_b)
			accumulator_out_r <= `AIC_RST_WORD;
		else if (clk_en)
			accumulator_out_r <= acc_word_nxt;
	end

	// Interrupt request from enabled flags
	always @* begin
		irq_nxt = (done_r & en_r[`AIC_EN_DONE_INT])
			| (err_r & en_r[`AIC_EN_ERR_INT]);
	end

	// Registered interrupt line, one cycle behind the flags
	always @(posedge core_clk) begin
		if (!rst_b)
			interrupt_request_line_r <= 1'b0;
		else if (clk_en)
			interrupt_request_line_r <= irq_nxt;
	end

endmodule // aic_control_unit

// >>> src/aic_control_regs.vh
`ifndef AIC_CONTROL_REGS_VH
`define AIC_CONTROL_REGS_VH

// Instruction word fields, 12 bits, written 6XYn in octal
`define AIC_IOT_PREFIX     3'h6
`define AIC_IOT_PRE_HI     11
`define AIC_IOT_PRE_LO     9
`define AIC_IOT_DEV_HI     8
`define AIC_IOT_DEV_LO     3
`define AIC_IOT_OP_HI      2
`define AIC_IOT_OP_LO      0

// Operation codes in the low octal digit
`define AIC_OP_CLEAR_ALL   3'h0
`define AIC_OP_LOAD_CHAN   3'h1
`define AIC_OP_BEGIN       3'h2
`define AIC_OP_READ_RES    3'h3
`define AIC_OP_SKIP_DONE   3'h4
`define AIC_OP_SKIP_ERR    3'h5
`define AIC_OP_LOAD_EN     3'h6
`define AIC_OP_READ_REGS   3'h7

// Enable register, held as accumulator bits 2..7 (vector bits 9..4)
`define AIC_EN_HI          9
`define AIC_EN_LO          4
`define AIC_EN_DONE_INT    5
`define AIC_EN_ERR_INT     4
`define AIC_EN_EXT_START   3
`define AIC_EN_AUTO_INC    2
`define AIC_EN_UNIPOLAR    1
`define AIC_EN_UNUSED      0

// Channel register, accumulator bits 8..11 (vector bits 3..0)
`define AIC_CHAN_HI        3
`define AIC_CHAN_LO        0

// Reset values
`define AIC_RST_EN         6'h00
`define AIC_RST_CHAN       4'h0
`define AIC_RST_WORD       12'h000
`define AIC_RST_FLAG       1'b0

// Timing, in nanoseconds
`define AIC_CLK_NS         100
`define AIC_SETTLE_NS      11000
`define AIC_UPDATE_NS      1000

`endif

// >>> testbench/aic_props.sv
`timescale 1ns/1ps
module aic_props (
	// Clock, reset, bus inputs
	input logic        core_clk,
	input logic        rst_b,
	input logic        clk_en,
	input logic [5:0]  code_switch_bank,
	input logic        iot_valid,
	input logic [11:0] iot_word,
	input logic [11:0] accumulator_in,
	// Unit outputs
	input logic [11:0] accumulator_out_r,
	input logic        accumulator_clear_r,
	input logic        skip_r,
	input logic        iot_ack_r,
	input logic        unipolar_mode_r,
	input logic        convert_go_r,
	input logic        sar_ready_r
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	// Decode against the switch code
	wire hit = iot_valid && clk_en && iot_word[11:9] == 3'h6 && iot_word[8:3] == ~code_switch_bank;
	wire [2:0] op = iot_word[2:0];
	logic [7:0] cnt;
	logic       pend;
	// Cycles since an accepted program start
	always @(posedge core_clk) begin
		if (!rst_b) begin
			cnt <= 8'h00;
			pend <= 1'b0;
		end else if (hit && op == 3'h2 && !pend) begin
			cnt <= 8'h00;
			pend <= 1'b1;
		end else begin
			if (cnt != 8'hff) cnt <= cnt + 8'h01;
			if (convert_go_r) pend <= 1'b0;
		end
	end
	ack_on_match_a: assert property (hit |=> iot_ack_r) else $error("no ack");
	refuse_other_a: assert property (!hit |=> !iot_ack_r) else $error("stray ack");
	clear_pulse_a: assert property (hit && (op == 3'h1 || op == 3'h6) |=> accumulator_clear_r)
		else $error("no clear");
	skip_gate_a: assert property (!(hit && op[2:1] == 2'b10) |=> !skip_r) else $error("bad skip");
	settle_time_a: assert property (convert_go_r && pend |-> cnt >= 8'h6d && cnt <= 8'h73)
		else $error("settle wrong");
	range_load_a: assert property (hit && op == 3'h6 |=> unipolar_mode_r == $past(accumulator_in[5]))
		else $error("range wrong");
	sign_ext_a: assert property (hit && op == 3'h3 |=> accumulator_out_r[11:10] == {2{accumulator_out_r[9]}})
		else $error("no sign ext");
	reset_clear_a: assert property ($rose(rst_b) |-> !iot_ack_r && !sar_ready_r && !convert_go_r)
		else $error("reset state");
	cover property (hit && op == 3'h2);
	cover property (convert_go_r);
	cover property (skip_r);
endmodule // aic_props
bind aic_control_unit aic_props u_props (.core_clk, .rst_b, .clk_en, .code_switch_bank,
	.iot_valid, .iot_word, .accumulator_in, .accumulator_out_r, .accumulator_clear_r,
	.skip_r, .iot_ack_r, .unipolar_mode_r, .convert_go_r, .sar_ready_r);

// >>> testbench/aic_sar_model.sv
`timescale 1ns/1ps
module aic_sar_model #(parameter [9:0] VALUE = 10'h2a5) (
	// Clock, reset, latency
	input logic        core_clk,
	input logic        rst_b,
	input logic [3:0]  lat,
	// Handshake with the unit
	input logic        convert_go_r,
	input logic        sar_ready_r,
	output logic       sar_valid,
	output logic [9:0] sar_data
);
	logic [3:0] dly;
	// Convert for lat cycles, hold word until taken, inverse when idle
	always @(posedge core_clk) begin
		if (!rst_b) begin
			dly <= 4'h0;
			sar_valid <= 1'b0;
			sar_data <= ~VALUE;
		end else if (sar_valid) begin
			if (sar_ready_r) begin
				sar_valid <= 1'b0;
				sar_data <= ~VALUE;
			end
		end else if (convert_go_r) dly <= lat;
		else if (dly != 4'h0) begin
			dly <= dly - 4'h1;
			if (dly == 4'h1) begin
				sar_valid <= 1'b1;
				sar_data <= VALUE;
			end
		end
	end
endmodule // aic_sar_model

// >>> testbench/aic_tb.sv
`timescale 1ns/1ps
module testbench;
	localparam [5:0] DC = 6'h2b;
	logic core_clk = 0, rst_b = 0, iot_valid = 0, clock_overflow = 0, external_trigger_n = 1;
	logic [11:0] iot_word = 0, accumulator_in = 0, accumulator_out_r;
	logic ld, clr, skp, ack, irq, go, sar_valid, rdy, unip, f;
	logic [3:0] chan, lat = 4'h1;
	logic [9:0] sar_data;
	int miscompares = 0, n_checks = 0, cyc = 0;
	always #50 core_clk = ~core_clk;
	aic_control_unit dut (.core_clk, .rst_b, .clk_en(1'b1), .code_switch_bank(~DC),
		.iot_valid, .iot_word, .accumulator_in, .accumulator_out_r, .accumulator_load_r(ld),
		.accumulator_clear_r(clr), .skip_r(skp), .iot_ack_r(ack), .interrupt_request_line_r(irq),
		.clock_overflow, .external_trigger_n, .channel_selector_r(chan), .unipolar_mode_r(unip),
		.convert_go_r(go), .sar_valid, .sar_data, .sar_ready_r(rdy));
	aic_sar_model partner (.core_clk, .rst_b, .lat, .convert_go_r(go), .sar_ready_r(rdy),
		.sar_valid, .sar_data);
	// Hang guard
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			miscompares++;
			close_out;
		end
	end
	task chk(input string nm, input logic [11:0] s, e);
		n_checks++;
		if (s !== e) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask
	task iot(input [2:0] op, input [11:0] ac, input [5:0] dc = DC);
		@(posedge core_clk);
		iot_valid <= 1;
		iot_word <= {3'h6, dc, op};
		accumulator_in <= ac;
		@(posedge core_clk);
		iot_valid <= 0;
		#1;
	endtask
	task wait_go;
		f = 0;
		for (int i = 0; i < 150 && !f; i++) begin
			@(posedge core_clk);
			#1 f = go;
		end
	endtask
	task t_regs;
		iot(7, 0);
		chk("regs", accumulator_out_r, 0);
		chk("load", ld, 1);
		chk("ack", ack, 1);
		iot(7, 0, 6'h2a);
		chk("ack", ack, 0);
		iot(6, 12'h260);
		chk("clr", clr, 1);
		chk("unip", unip, 1);
		iot(1, 12'h00f);
		chk("chan", chan, 4'hf);
		iot(7, 0);
		chk("regs", accumulator_out_r, 12'h26f);
		$display("register test done");
	endtask
	task t_conv;
		iot(2, 0);
		wait_go;
		chk("go", f, 1);
		for (int i = 0; i < 40 && !skp; i++) iot(4, 0);
		chk("skip", skp, 1);
		repeat (12) @(posedge core_clk);
		chk("irq", irq, 1);
		chk("chan", chan, 0);
		iot(3, 0);
		chk("result", accumulator_out_r, 12'hea5);
		chk("load", ld, 1);
		iot(4, 0);
		chk("skip", skp, 0);
		chk("irq", irq, 0);
		$display("conversion test done");
	endtask
	task t_err;
		iot(6, 12'h100);
		iot(1, 12'h005);
		iot(2, 0);
		iot(2, 0);
		iot(5, 0);
		chk("skip", skp, 1);
		@(posedge core_clk);
		chk("irq", irq, 1);
		iot(0, 0);
		iot(7, 0);
		chk("regs", accumulator_out_r, 0);
		repeat (150) @(posedge core_clk);
		$display("error test done");
	endtask
	task t_ext;
		lat <= 4'h9;
		iot(6, 12'h080);
		external_trigger_n <= 0;
		wait_go;
		chk("go", f, 1);
		repeat (40) @(posedge core_clk);
		external_trigger_n <= 1;
		clock_overflow <= 1;
		@(posedge core_clk);
		clock_overflow <= 0;
		wait_go;
		chk("go", f, 1);
		repeat (40) @(posedge core_clk);
		iot(0, 0);
		external_trigger_n <= 0;
		wait_go;
		chk("go", f, 0);
		$display("start source test done");
	endtask
	task close_out;
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge core_clk);
		rst_b <= 1;
		t_regs;
		t_conv;
		t_err;
		t_ext;
		close_out;
	end
endmodule // testbench
